// File: rtl/rid_defs.vh
// Constants for the 14-bit instruction decoder and executor
`ifndef RID_DEFS_VH
`define RID_DEFS_VH
// Quarter-cycle phases per instruction cycle
`define RID_PHASES 3'h4
`define RID_PHASE_LAST 2'h3
// Opcode class, bits 13:12
`define RID_CLS_BYTE 2'h0
`define RID_CLS_BIT 2'h1
`define RID_CLS_JMP 2'h2
`define RID_CLS_LIT 2'h3
// Byte-oriented nibbles, bits 11:8
`define RID_B_MOVWF 4'h0
`define RID_B_CLR 4'h1
`define RID_B_SUB 4'h2
`define RID_B_DEC 4'h3
`define RID_B_OR 4'h4
`define RID_B_AND 4'h5
`define RID_B_XOR 4'h6
`define RID_B_ADD 4'h7
`define RID_B_MOV 4'h8
`define RID_B_COM 4'h9
`define RID_B_INC 4'hA
`define RID_B_DECSKP 4'hB
`define RID_B_RRC 4'hC
`define RID_B_RLC 4'hD
`define RID_B_SWAP 4'hE
`define RID_B_INCSKP 4'hF
// Control words with nibble 0 and d clear
`define RID_W_RETURN 8'h08
`define RID_W_IRQ_EXIT 8'h09
`define RID_W_STANDBY 8'h63
`define RID_W_WDT_KICK 8'h64
`define RID_W_CLRACC 8'h03
// Bit-oriented sub-codes, bits 11:10
`define RID_T_CLR 2'h0
`define RID_T_SET 2'h1
`define RID_T_SKZ 2'h2
`define RID_T_SKO 2'h3
// Literal nibbles, bits 11:8
`define RID_L_OR 4'h8
`define RID_L_AND 4'h9
`define RID_L_XOR 4'hA
// File addresses of interest
`define RID_F_TIMER 7'h01
`define RID_F_STATUS 7'h03
`define RID_F_PORT_LO 7'h05
`define RID_F_PORT_HI 7'h09
// Status bit positions
`define RID_S_C 0
`define RID_S_DC 1
`define RID_S_Z 2
`define RID_S_PD 3
`define RID_S_TO 4
// Reset values
`define RID_ACC_RST 8'h00
`define RID_STATUS_RST 8'h18
`endif

// File: rtl/rid_phase_gen.v
// Four-phase sequencer giving one enable pulse per instruction cycle
`timescale 1ns/1ps
`include "rid_defs.vh"
module rid_phase_gen (
  input wire sys_clk_in,
  input wire rst_n_in,
  output wire cycle_en_out,
  output wire [1:0] phase_out
);
  reg [1:0] phase_q;
  // ==========================================
  // Phase counter
  // Wraps every four clocks so one instruction cycle is four periods
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end
  assign cycle_en_out = (phase_q == `RID_PHASE_LAST);
  assign phase_out = phase_q;
endmodule // rid_phase_gen

// File: rtl/rid_core.v
// Instruction decoder and executor for a 14-bit-word accumulator core
`timescale 1ns/1ps
`include "rid_defs.vh"
module rid_core (
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire [13:0] instr_word_in,
  input wire [7:0] file_rdata_in,
  input wire [7:0] port_pins_in,
  input wire [12:0] stack_top_in,
  input wire prescaler_on_timer_in,
  output reg [12:0] pc_out,
  output reg fetch_out,
  output reg [6:0] file_addr_out,
  output reg [7:0] file_wdata_out,
  output reg file_we_out,
  output reg [7:0] acc_out,
  output reg [7:0] status_out,
  output reg stack_push_out,
  output reg stack_pop_out,
  output reg [12:0] stack_push_addr_out,
  output reg global_irq_enable_out,
  output reg standby_out,
  output reg watchdog_clear_out,
  output reg prescaler_clear_out,
  output wire [1:0] phase_out
);
  // ==========================================
  // Cycle sequencing
  wire cycle_en;
  wire [1:0] phase;
  rid_phase_gen u_phase (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .cycle_en_out(cycle_en),
    .phase_out(phase)
  );
  assign phase_out = phase;

  // ==========================================
  // Pin synchroniser for port reads
  reg [7:0] pins_meta_q;
  reg [7:0] pins_q;
  // Two stages since pins are asynchronous to the core clock
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pins_meta_q <= 8'h00;
      pins_q <= 8'h00;
    end else begin
      pins_meta_q <= port_pins_in;
      pins_q <= pins_meta_q;
    end
  end

  // ==========================================
  // Instruction field decode
  wire [1:0] cls = instr_word_in[13:12];
  wire [3:0] nib = instr_word_in[11:8];
  wire dest_file = instr_word_in[7];
  wire [6:0] faddr = instr_word_in[6:0];
  wire [2:0] bsel = instr_word_in[9:7];
  wire [1:0] bop = instr_word_in[11:10];
  wire [7:0] lit = instr_word_in[7:0];
  reg flush_q;
  reg flush_br_q;
  wire is_port = (faddr >= `RID_F_PORT_LO) && (faddr <= `RID_F_PORT_HI);
  wire [7:0] fval = is_port ? pins_q : file_rdata_in;
  wire [7:0] bmask = 8'h01 << bsel;

  // Combinational address so the file answers within the cycle
  always @* begin
    file_addr_out = faddr;
  end

  // ==========================================
  // Execute datapath
  reg [7:0] res;
  reg [7:0] acc_d;
  reg [7:0] st_d;
  reg wr_file;
  reg wr_acc;
  reg skip;
  reg branch;
  reg [12:0] target;
  reg push;
  reg pop;
  reg irq_on;
  reg sleep_go;
  reg kick;
  reg [8:0] sum9;
  reg [4:0] sum5;
  always @* begin
    res = 8'h00;
    acc_d = acc_out;
    st_d = status_out;
    wr_file = 1'b0;
    wr_acc = 1'b0;
    skip = 1'b0;
    branch = 1'b0;
    target = pc_out + 13'h0001;
    push = 1'b0;
    pop = 1'b0;
    irq_on = 1'b0;
    sleep_go = 1'b0;
    kick = 1'b0;
    sum9 = 9'h000;
    sum5 = 5'h00;
    case (cls)
      `RID_CLS_BYTE: begin
        if (nib == 4'h0 && !dest_file) begin
          if (lit == `RID_W_RETURN) begin
            pop = 1'b1;
            branch = 1'b1;
            target = stack_top_in;
          end else if (lit == `RID_W_IRQ_EXIT) begin
            pop = 1'b1;
            branch = 1'b1;
            irq_on = 1'b1;
            target = stack_top_in;
          end else if (lit == `RID_W_STANDBY) begin
            sleep_go = 1'b1;
            kick = 1'b1;
            st_d[`RID_S_TO] = 1'b1;
            st_d[`RID_S_PD] = 1'b0;
          end else if (lit == `RID_W_WDT_KICK) begin
            kick = 1'b1;
            st_d[`RID_S_TO] = 1'b1;
            st_d[`RID_S_PD] = 1'b1;
          end
        end else begin
          case (nib)
            `RID_B_MOVWF: res = acc_out;
            `RID_B_CLR: res = 8'h00;
            `RID_B_SUB: begin
              sum9 = {1'b0, fval} + {1'b0, ~acc_out} + 9'h001;
              sum5 = {1'b0, fval[3:0]} + {1'b0, ~acc_out[3:0]} + 5'h01;
              res = sum9[7:0];
            end
            `RID_B_ADD: begin
              sum9 = {1'b0, fval} + {1'b0, acc_out};
              sum5 = {1'b0, fval[3:0]} + {1'b0, acc_out[3:0]};
              res = sum9[7:0];
            end
            `RID_B_DEC, `RID_B_DECSKP: res = fval - 8'h01;
            `RID_B_INC, `RID_B_INCSKP: res = fval + 8'h01;
            `RID_B_OR: res = acc_out | fval;
            `RID_B_AND: res = acc_out & fval;
            `RID_B_XOR: res = acc_out ^ fval;
            `RID_B_MOV: res = fval;
            `RID_B_COM: res = ~fval;
            `RID_B_RRC: res = {status_out[`RID_S_C], fval[7:1]};
            `RID_B_RLC: res = {fval[6:0], status_out[`RID_S_C]};
            default: res = {fval[3:0], fval[7:4]};
          endcase
          if (nib == `RID_B_MOVWF || (nib == `RID_B_CLR && dest_file)) begin
            wr_file = 1'b1;
          end else begin
            wr_file = dest_file;
            wr_acc = !dest_file;
          end
          // Zero flag for the arithmetic and logic group
          if (nib == `RID_B_CLR || nib == `RID_B_SUB || nib == `RID_B_DEC ||
              nib == `RID_B_OR || nib == `RID_B_AND || nib == `RID_B_XOR ||
              nib == `RID_B_ADD || nib == `RID_B_MOV || nib == `RID_B_COM ||
              nib == `RID_B_INC) begin
            st_d[`RID_S_Z] = (res == 8'h00);
          end
          if (nib == `RID_B_SUB || nib == `RID_B_ADD) begin
            st_d[`RID_S_C] = sum9[8];
            st_d[`RID_S_DC] = sum5[4];
          end
          if (nib == `RID_B_RRC) begin
            st_d[`RID_S_C] = fval[0];
          end
          if (nib == `RID_B_RLC) begin
            st_d[`RID_S_C] = fval[7];
          end
          if (nib == `RID_B_DECSKP && res == 8'h00) begin
            skip = 1'b1;
          end
          if (nib == `RID_B_INCSKP && res == 8'h00) begin
            skip = 1'b1;
          end
        end
      end
      `RID_CLS_BIT: begin
        case (bop)
          `RID_T_CLR: begin
            res = fval & ~bmask;
            wr_file = 1'b1;
          end
          `RID_T_SET: begin
            res = fval | bmask;
            wr_file = 1'b1;
          end
          `RID_T_SKZ: skip = ((fval & bmask) == 8'h00);
          default: skip = ((fval & bmask) != 8'h00);
        endcase
      end
      `RID_CLS_JMP: begin
        branch = 1'b1;
        target = {pc_out[12:11], instr_word_in[10:0]};
        push = !instr_word_in[11];
      end
      default: begin
        if (nib[3:2] == 2'h0) begin
          acc_d = lit;
        end else if (nib[3:2] == 2'h1) begin
          acc_d = lit;
          pop = 1'b1;
          branch = 1'b1;
          target = stack_top_in;
        end else if (nib[3:1] == 3'h6 || nib[3:1] == 3'h7) begin
          if (nib[1]) begin
            sum9 = {1'b0, lit} + {1'b0, acc_out};
            sum5 = {1'b0, lit[3:0]} + {1'b0, acc_out[3:0]};
          end else begin
            sum9 = {1'b0, lit} + {1'b0, ~acc_out} + 9'h001;
            sum5 = {1'b0, lit[3:0]} + {1'b0, ~acc_out[3:0]} + 5'h01;
          end
          acc_d = sum9[7:0];
          st_d[`RID_S_C] = sum9[8];
          st_d[`RID_S_DC] = sum5[4];
          st_d[`RID_S_Z] = (sum9[7:0] == 8'h00);
        end else if (nib == `RID_L_OR || nib == `RID_L_AND || nib == `RID_L_XOR) begin
          if (nib == `RID_L_OR) begin
            acc_d = acc_out | lit;
          end else if (nib == `RID_L_AND) begin
            acc_d = acc_out & lit;
          end else begin
            acc_d = acc_out ^ lit;
          end
          st_d[`RID_S_Z] = (acc_d == 8'h00);
        end
      end
    endcase
    if (wr_acc) begin
      acc_d = res;
    end
  end

  // ==========================================
  // Commit at the end of each instruction cycle
  // A flushed cycle is the no-op second half of a skip or branch
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pc_out <= 13'h0000;
      acc_out <= `RID_ACC_RST;
      status_out <= `RID_STATUS_RST;
      flush_q <= 1'b0;
      flush_br_q <= 1'b0;
      file_wdata_out <= 8'h00;
      file_we_out <= 1'b0;
      stack_push_out <= 1'b0;
      stack_pop_out <= 1'b0;
      stack_push_addr_out <= 13'h0000;
      global_irq_enable_out <= 1'b0;
      standby_out <= 1'b0;
      watchdog_clear_out <= 1'b0;
      prescaler_clear_out <= 1'b0;
      fetch_out <= 1'b0;
    end else begin
      file_we_out <= 1'b0;
      stack_push_out <= 1'b0;
      stack_pop_out <= 1'b0;
      watchdog_clear_out <= 1'b0;
      prescaler_clear_out <= 1'b0;
      fetch_out <= cycle_en && !standby_out; // Standby freezes fetches too
      if (cycle_en && !standby_out) begin
        if (flush_q) begin
          flush_q <= 1'b0;
          // A branch already points at its target, so only a skip moves on
          if (!flush_br_q) begin
            pc_out <= pc_out + 13'h0001;
          end
        end else begin
          acc_out <= acc_d;
          // Writes to status win over flag updates, except TO and PD, which keep the flag logic's value
          if (wr_file && faddr == `RID_F_STATUS) begin
            status_out <= (res & 8'hE7) | (st_d & 8'h18);
          end else begin
            status_out <= st_d;
          end
          file_wdata_out <= res;
          file_we_out <= wr_file;
          prescaler_clear_out <= wr_file && (faddr == `RID_F_TIMER) && prescaler_on_timer_in;
          stack_push_out <= push;
          stack_pop_out <= pop;
          stack_push_addr_out <= pc_out + 13'h0001;
          if (irq_on) begin
            global_irq_enable_out <= 1'b1;
          end
          watchdog_clear_out <= kick;
          standby_out <= sleep_go;
          flush_q <= skip || branch;
          flush_br_q <= branch;
          pc_out <= skip ? pc_out + 13'h0001 : target;
        end
      end
    end
  end
endmodule // rid_core

// File: test/rid_core_sva.sv
// Concurrent checks on the decoder ports
`timescale 1ns/1ps
module rid_core_sva (
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire [13:0] instr_word_in,
  input wire [12:0] stack_top_in,
  input wire prescaler_on_timer_in,
  input wire [12:0] pc_out,
  input wire fetch_out,
  input wire [6:0] file_addr_out,
  input wire file_we_out,
  input wire [7:0] status_out,
  input wire stack_push_out,
  input wire stack_pop_out,
  input wire [12:0] stack_push_addr_out,
  input wire global_irq_enable_out,
  input wire standby_out,
  input wire watchdog_clear_out,
  input wire prescaler_clear_out,
  input wire [1:0] phase_out
);
  // ==========
  // Timing and flag checks, all in one clock domain
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  phase_step_a: assert property (
    !standby_out |=> phase_out == $past(phase_out) + 2'h1) else $error("phase skipped");
  fetch_gap_a: assert property (
    fetch_out |-> $past(phase_out) == 2'h3 ##1 !fetch_out [*3]) else $error("fetch spacing");
  out_stands_a: assert property (
    phase_out != 2'h3 |=> $stable(pc_out) && $stable(status_out)) else $error("early update");
  write_pulse_a: assert property (
    file_we_out |-> fetch_out ##1 !file_we_out) else $error("write pulse shape");
  presc_clear_a: assert property (
    prescaler_clear_out |-> file_we_out && $past(file_addr_out) == 7'h01
      && $past(prescaler_on_timer_in)) else $error("stray prescaler clear");
  skip_flags_a: assert property (
    fetch_out && $past(file_addr_out) != 7'h03
      && $past(instr_word_in[13:8]) inside {6'h0B, 6'h0F} |-> $stable(status_out))
    else $error("skip op touched flags");
  logic_zero_a: assert property (
    fetch_out && $past(file_addr_out) != 7'h03
      && $past(instr_word_in[13:8]) inside {6'h04, 6'h05, 6'h06, 6'h38, 6'h39, 6'h3A}
      |-> (status_out & 8'hFB) == ($past(status_out) & 8'hFB)) else $error("logic op flags");
  rot_carry_a: assert property (
    fetch_out && $past(file_addr_out) != 7'h03 && $past(instr_word_in[13:8]) inside {6'h0C, 6'h0D}
      |-> (status_out & 8'hFE) == ($past(status_out) & 8'hFE)) else $error("rotate flags");
  pop_pc_a: assert property (
    stack_pop_out |-> fetch_out && pc_out == $past(stack_top_in)) else $error("pop target");
  irq_exit_a: assert property (
    stack_pop_out && $past(instr_word_in) == 14'h0009 |-> global_irq_enable_out)
    else $error("irq enable not set");
  standby_a: assert property (
    $rose(standby_out) |-> watchdog_clear_out && status_out[4:3] == 2'h2 ##1 !fetch_out [*4])
    else $error("standby entry");
  wdt_kick_a: assert property (
    watchdog_clear_out && !standby_out |-> status_out[4:3] == 2'h3) else $error("kick flags");
  call_push_a: assert property (
    stack_push_out |-> stack_push_addr_out == $past(pc_out) + 13'h1
      && pc_out[10:0] == $past(instr_word_in[10:0])) else $error("call push");
endmodule // rid_core_sva
bind rid_core rid_core_sva i_rid_core_sva (.*);

// File: test/rid_prog_mem.sv
// Program memory model feeding instruction words by program counter
`timescale 1ns/1ps
module rid_prog_mem (
  input wire [12:0] addr_in,
  output wire [13:0] word_out
);
  logic [13:0] mem [4];
  // Only four words are loaded; anything beyond reads as a no-op
  assign word_out = (addr_in < 13'h4) ? mem[addr_in[1:0]] : 14'h0000;
  // Slot 2 loads a marker literal so a skip shows in the accumulator
  initial begin
    mem[2] = 14'h30A5;
    mem[3] = 14'h0000;
  end
endmodule // rid_prog_mem

// File: test/risc14_instruction_decoder_tb.sv
// Self-checking bench: one test word per reset, expectations queued per cycle
`timescale 1ns/1ps
module risc14_instruction_decoder_tb;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] s;
    logic [12:0] p;
    logic cp;
    logic we;
    logic [7:0] wd;
    logic [5:0] ev;
  } rid_note_t;
  logic sys_clk_in, rst_n_in, prescaler_on_timer_in, fetch_out, file_we_out;
  logic stack_push_out, stack_pop_out, global_irq_enable_out, standby_out;
  logic watchdog_clear_out, prescaler_clear_out;
  logic [13:0] instr_word_in;
  logic [7:0] file_rdata_in, port_pins_in, acc_out, status_out, file_wdata_out;
  logic [12:0] stack_top_in, pc_out, stack_push_addr_out;
  logic [6:0] file_addr_out;
  logic [1:0] phase_out;
  rid_note_t q[$];
  rid_note_t n;
  int miscompares = 0;
  int cmp_count = 0;
  logic [3:0] lit [8] = '{4'h8, 4'h9, 4'hA, 4'hC, 4'hD, 4'hE, 4'hF, 4'h4};
  logic [3:0] byt [12] = '{4'h4, 4'h5, 4'h6, 4'hB, 4'hF, 4'hC, 4'hD, 4'h3, 4'h8, 4'h9, 4'hA,
    4'hE};
  logic [6:0] fa [5] = '{7'h01, 7'h05, 7'h09, 7'h07, 7'h2C};
  logic [13:0] ctl [7] = '{14'h0008, 14'h0009, 14'h0064, 14'h0001, 14'h21A5, 14'h2E33, 14'h0063};
  rid_core i_rid_core (.*);
  rid_prog_mem i_rid_prog_mem (.addr_in(pc_out), .word_out(instr_word_in));
  // ==========
  // Clock, 5 ns period
  initial begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end
  task automatic chk(input string nm, input logic [12:0] e, input logic [12:0] g);
    cmp_count++;
    if (e !== g) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    if (miscompares == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Mid-clock watcher: each fetch pulse retires the oldest note
  always @(negedge sys_clk_in) begin
    if (fetch_out === 1'b1 && q.size() > 0) begin
      n = q.pop_front();
      chk("acc", n.a, acc_out);
      chk("status", n.s, status_out);
      if (n.cp) chk("pc", n.p, pc_out);
      chk("we", n.we, file_we_out);
      if (n.we) chk("wdata", n.wd, file_wdata_out);
      chk("events", n.ev,
        {standby_out, global_irq_enable_out, stack_pop_out, stack_push_out,
        watchdog_clear_out, prescaler_clear_out});
    end
  end
  // Reset, load literal then test word, predict three cycles (two for standby), wait for retirement
  task automatic run(input logic [7:0] a, input logic [13:0] w, input logic [7:0] fv);
    rid_note_t m;
    logic [7:0] op;
    logic [7:0] r;
    logic [8:0] x;
    logic sk, br, wr, ad;
    int t;
    @(posedge sys_clk_in);
    rst_n_in <= 1'b0;
    file_rdata_in <= fv;
    port_pins_in <= 8'($urandom);
    stack_top_in <= 13'($urandom);
    prescaler_on_timer_in <= 1'($urandom);
    @(posedge sys_clk_in);
    i_rid_prog_mem.mem[0] = {6'h30, a};
    i_rid_prog_mem.mem[1] = w;
    repeat (9) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    op = (w[6:0] >= 7'h05 && w[6:0] <= 7'h09) ? port_pins_in : fv;
    m = '{a, 8'h18, 13'h1, 1'b1, 1'b0, 8'h00, 6'h00};
    q.push_back(m);
    m.p = 13'h2;
    {sk, br, wr, ad} = 4'h0;
    r = a;
    case (w[13:12])
      2'h0: begin
        if (w[11:7] == 5'h00) begin
          case (w[6:0])
            7'h08: m.ev = 6'h08;
            7'h09: m.ev = 6'h18;
            7'h63: m.ev = 6'h22;
            7'h64: m.ev = 6'h02;
            default: ;
          endcase
          br = m.ev[3];
          if (w[6:0] == 7'h63) m.s = 8'h10;
        end else begin
          case (w[11:8])
            4'h4: r = a | op;
            4'h5: r = a & op;
            4'h6: r = a ^ op;
            4'h3, 4'hB: r = op - 8'h01;
            4'h8: r = op;
            4'h9: r = ~op;
            4'hE: r = {op[3:0], op[7:4]};
            4'hC: {r, m.s[0]} = {m.s[0], op};
            4'hD: {m.s[0], r} = {op, m.s[0]};
            default: r = op + 8'h01;
          endcase
          if (w[11:8] < 4'h7 || w[11:8] inside {4'h8, 4'h9, 4'hA}) m.s[2] = (r == 8'h00);
          sk = w[11] & w[9] & w[8] & (r == 8'h00);
          wr = w[7];
          ad = ~w[7];
        end
      end
      2'h1: begin
        r = op;
        r[w[9:7]] = w[10];
        wr = ~w[11];
        sk = w[11] & (op[w[9:7]] == w[10]);
      end
      2'h2: begin
        m.p = {2'b00, w[10:0]};
        m.ev[2] = ~w[11];
        br = 1'b1;
      end
      default: begin
        ad = 1'b1;
        if (w[11:10] == 2'h3) begin
          op = w[9] ? a : ~a;
          x = {1'b0, w[7:0]} + op + !w[9];
          m.s[1] = ({1'b0, w[3:0]} + op[3:0] + !w[9]) > 5'h0F;
          m.s[0] = x[8];
          r = x[7:0];
        end else if (w[11]) r = w[9] ? a ^ w[7:0] : (w[8] ? a & w[7:0] : a | w[7:0]);
        else r = w[7:0];
        if (w[11]) m.s[2] = (r == 8'h00);
        m.ev[3] = (w[11:10] == 2'h1);
        br = m.ev[3];
      end
    endcase
    if (m.ev[3]) m.p = stack_top_in;
    if (ad) m.a = r;
    m.we = wr;
    m.wd = r;
    m.ev[0] = wr & (w[6:0] == 7'h01) & prescaler_on_timer_in;
    q.push_back(m);
    // Following cycle: flushed slot, or the marker literal when nothing skipped or branched
    m.ev = m.ev & 6'h30;
    m.we = 1'b0;
    // A branch sits at its target through the no-op slot
    if (!br) m.p = 13'h3;
    m.cp = 1'b1;
    if (!(sk | br)) m.a = 8'hA5;
    if (w != 14'h0063) q.push_back(m);
    for (t = 0; t < 40 && q.size() > 0; t++) @(posedge sys_clk_in);
    // Let the sleep window run so the frozen fetch can be watched
    if (w == 14'h0063) repeat (8) @(posedge sys_clk_in);
    if (q.size() > 0) begin
      miscompares++;
      conclude();
    end
  endtask
  // ==========
  // Main sequence
  initial begin
    int i;
    logic [13:0] tw;
    rst_n_in = 1'b0;
    file_rdata_in = 8'h00;
    port_pins_in = 8'h00;
    stack_top_in = 13'h0000;
    prescaler_on_timer_in = 1'b0;
    void'($urandom(32'hBF96));
    for (i = 0; i < 32; i++) begin
      run(8'($urandom), {2'h3, lit[i % 8], 8'($urandom)}, 8'h00);
    end
    run(8'h10, 14'h3EF0, 8'h00);
    run(8'h5A, 14'h3C5A, 8'h00);
    for (i = 0; i < 60; i++) begin
      tw = {2'h0, byt[i % 12], 1'($urandom), fa[i % 5]};
      run(8'($urandom), tw, 8'($urandom));
    end
    run(8'($urandom), 14'h0BAC, 8'h01);
    run(8'($urandom), 14'h0F81, 8'hFF);
    for (i = 0; i < 32; i++) begin
      tw = {2'h1, 2'(i), 3'(i >> 2), fa[i % 5]};
      run(8'($urandom), tw, 8'($urandom));
    end
    for (i = 0; i < 7; i++) begin
      run(8'($urandom), ctl[i], 8'($urandom));
    end
    conclude();
  end
endmodule // risc14_instruction_decoder_tb
